// >>> src/bnsh_cfg.svh
// Constants for the bus node SPI host port
`ifndef BNSH_CFG_SVH
`define BNSH_CFG_SVH
`define BNSH_CLK_MHZ 100
`define BNSH_REQ_NS 1000
`define BNSH_REQ_CYC ((`BNSH_REQ_NS * `BNSH_CLK_MHZ + 999) / 1000)
`define BNSH_EOM_BITS 10
`define BNSH_BIT_NS 8000
`define BNSH_BYTE_BITS 8
`define BNSH_CNT_W 20
`define BNSH_MSG_DEPTH 16
`endif

// >>> src/bnsh_host.sv
// Host-side slave SPI controller for the bus node
`timescale 1ns/1ps
`default_nettype none
`include "bnsh_cfg.svh"
module bnsh_host #(
    parameter int CLK_MHZ = `BNSH_CLK_MHZ,
    parameter int BIT_NS = `BNSH_BIT_NS,
    parameter int EOM_BITS = `BNSH_EOM_BITS,
    parameter int DEPTH = `BNSH_MSG_DEPTH,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Device pins
    input wire logic sckPin,
    input wire logic nodeTxPin,
    output logic nodeRxPin,
    input wire logic ctrlIn,
    output logic ctrlOut,
    output logic ctrlOe,
    input wire logic idleNPin,
    output logic modeSel,
    output logic chipSelN,
    // Message load
    input wire logic loadEn,
    input wire logic [AW-1:0] loadAddr,
    input wire logic [7:0] loadData,
    // Send command
    input wire logic sendStart,
    input wire logic [AW-1:0] sendLen,
    output logic sendBusy,
    output logic sendDone,
    output bnsh_pkg::bnsh_result_t sendResult,
    // Received bytes
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxFirst,
    // Framing resync request
    input wire logic resync
);
    import bnsh_pkg::*;

    localparam int REQ_CYC = (`BNSH_REQ_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT_CYC = BIT_NS * CLK_MHZ / 1000;
    localparam int EOM_CYC = EOM_BITS * BIT_CYC;

    // Synchronisers for device pins
    logic [1:0] sckSync_reg, txSync_reg, ctrlSync_reg, idleSync_reg;
    logic sckPrev_reg;
    // Slave shift state
    logic [7:0] shift_reg, shift_next;
    logic [2:0] bitCnt_reg;
    logic armed_reg;
    // Controller state
    bnsh_state_t state_reg, state_next;
    logic [`BNSH_CNT_W-1:0] cnt_reg;
    logic [AW-1:0] idx_reg;
    logic [AW-1:0] len_reg;
    logic [7:0] sent_reg;
    logic idlePrev_reg;
    logic [7:0] memData;
    logic [AW-1:0] memAddr;

    // Bit reversal, used for both directions
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7-i];
    endfunction

    // Decoded pin events
    wire sckS = sckSync_reg[1];
    wire sckRise = sckS && !sckPrev_reg;
    wire sckFall = !sckS && sckPrev_reg;
    wire ctrlS = ctrlSync_reg[1];
    wire idleS = idleSync_reg[1];
    wire idleFall = idlePrev_reg && !idleS;
    wire byteDone = sckFall && (bitCnt_reg == 3'h7);
    wire inXfer = (state_reg == BNSH_REQ) || (state_reg == BNSH_XFER);
    wire cntDone = (cnt_reg == '0);
    wire lastByte = (idx_reg == len_reg - 1'b1);

    // Fixed mode selection, SPI kept applied always
    assign modeSel = 1'b1;
    assign chipSelN = 1'b0;
    // Open-drain handshake, pulled low only for a request
    assign ctrlOut = 1'b0;
    assign ctrlOe = (state_reg == BNSH_REQ);
    assign sendBusy = (state_reg != BNSH_IDLE);
    // Next byte is fetched during the transfer, the read port is registered
    assign memAddr = (state_reg == BNSH_XFER) ? idx_reg + 1'b1 : idx_reg;

    // Outgoing bytes held in a small memory
    bnsh_msg_mem #(.DEPTH(DEPTH), .AW(AW)) bnsh_msg_mem_inst (
        .clk(clk),
        .ce(ce),
        .wrEn(loadEn),
        .wrAddr(loadAddr),
        .wrData(loadData),
        .rdAddr(memAddr),
        .rdData(memData)
    );

    // Two flops on every device pin
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sckSync_reg <= 2'h0;
            txSync_reg <= 2'h3;
            ctrlSync_reg <= 2'h3;
            idleSync_reg <= 2'h0;
            sckPrev_reg <= 1'b0;
            idlePrev_reg <= 1'b0;
        end
        else if (ce)
        begin
            sckSync_reg <= {sckSync_reg[0], sckPin};
            txSync_reg <= {txSync_reg[0], nodeTxPin};
            ctrlSync_reg <= {ctrlSync_reg[0], ctrlIn};
            idleSync_reg <= {idleSync_reg[0], idleNPin};
            sckPrev_reg <= sckS;
            idlePrev_reg <= idleS;
        end
    end

    // Slave shifter: clock idles low, sample on leading edge
    always_comb
    begin
        shift_next = shift_reg;
        if (sckRise)
            shift_next = {shift_reg[6:0], txSync_reg[1]};
    end

    // Slave port, selected while handshake is low
    always_ff @(posedge clk)
    begin
        if (!rst_n || resync)
        begin
            // Disable and reinit after framing error
            shift_reg <= 8'h00;
            bitCnt_reg <= 3'h0;
            nodeRxPin <= 1'b1;
            rxValid <= 1'b0;
            rxData <= 8'h00;
            armed_reg <= 1'b0;
        end
        else if (ce)
        begin
            rxValid <= 1'b0;
            if (state_reg == BNSH_REQ && !armed_reg)
            begin
                // Preload reversed byte in the first cycle of the request, with the handshake already low
                shift_reg <= rev8(sent_reg);
                nodeRxPin <= sent_reg[0];
                armed_reg <= 1'b1;
            end
            // Handshake rises with the last fall, so that fall must still count
            else if (!ctrlS || byteDone)
            begin
                shift_reg <= shift_next;
                if (sckFall)
                begin
                    // Next bit out while clock low
                    bitCnt_reg <= bitCnt_reg + 3'h1;
                    nodeRxPin <= shift_reg[7];
                end
                if (byteDone)
                begin
                    // Bytes arrive LSB first, reverse back
                    rxData <= rev8(shift_reg);
                    rxValid <= 1'b1;
                    armed_reg <= 1'b0;
                end
            end
        end
    end

    // First byte after idle is an identifier
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rxFirst <= 1'b1;
        else if (ce)
        begin
            if (idleFall)
                rxFirst <= 1'b1;
            else if (rxValid)
                rxFirst <= 1'b0;
        end
    end

    // Send sequence next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            BNSH_IDLE:
                if (sendStart && sendLen != '0)
                    state_next = BNSH_WAIT;
            BNSH_WAIT:
                if (!idleS && ctrlS)
                    state_next = BNSH_REQ;
            BNSH_REQ:
                if (cntDone)
                    state_next = BNSH_XFER;
            BNSH_XFER:
                if (rxValid)
                    state_next = BNSH_CHECK;
            BNSH_CHECK:
                if (rxData != sent_reg)
                    state_next = BNSH_IDLE;
                else if (lastByte)
                    state_next = BNSH_EOM;
                else
                    state_next = BNSH_REQ;
            BNSH_EOM:
                if (cntDone)
                    state_next = BNSH_IDLE;
            default:
                state_next = BNSH_IDLE;
        endcase
    end

    // Controller registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= BNSH_IDLE;
            cnt_reg <= '0;
            idx_reg <= '0;
            len_reg <= '0;
            sent_reg <= 8'h00;
            sendDone <= 1'b0;
            sendResult <= BNSH_OK;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            sendDone <= 1'b0;
            if (cnt_reg != '0)
                cnt_reg <= cnt_reg - 1'b1;
            case (state_reg)
                BNSH_IDLE:
                begin
                    idx_reg <= '0;
                    len_reg <= sendLen;
                end
                BNSH_WAIT:
                begin
                    // Loaded before the handshake drops
                    sent_reg <= memData;
                    cnt_reg <= `BNSH_CNT_W'(REQ_CYC);
                end
                BNSH_XFER:
                    // Clock arrived before our request was seen
                    if (sckRise && !armed_reg)
                        sendResult <= BNSH_WRITE_COLLISION_FLAG;
                BNSH_CHECK:
                begin
                    sendResult <= BNSH_OK;
                    if (rxData != sent_reg)
                    begin
                        // First byte lost arbitration, else collision
                        sendResult <= (idx_reg == '0) ? BNSH_LOST : BNSH_COLL;
                        sendDone <= 1'b1;
                    end
                    else if (lastByte)
                        cnt_reg <= `BNSH_CNT_W'(EOM_CYC);
                    else
                    begin
                        idx_reg <= idx_reg + 1'b1;
                        sent_reg <= memData;
                        cnt_reg <= `BNSH_CNT_W'(REQ_CYC);
                    end
                end
                BNSH_EOM:
                    if (cntDone)
                        sendDone <= 1'b1;
                default:
                    ;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> src/bnsh_msg_mem.sv
// Small message memory for outgoing bytes
`timescale 1ns/1ps
`default_nettype none
module bnsh_msg_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Write side
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read side
    input wire logic [AW-1:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] mem [DEPTH];
    // Registered write and read
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (wrEn)
                mem[wrAddr] <= wrData;
            rdData <= mem[rdAddr];
        end
    end
endmodule
`default_nettype wire

// >>> src/bnsh_pkg.sv
// Types for the bus node SPI host port
package bnsh_pkg;
    typedef enum logic [6:0] {
        BNSH_IDLE = 7'h01,
        BNSH_WAIT = 7'h02,
        BNSH_REQ = 7'h04,
        BNSH_XFER = 7'h08,
        BNSH_CHECK = 7'h10,
        BNSH_EOM = 7'h20,
        BNSH_RESYNC = 7'h40
    } bnsh_state_t;
    typedef enum logic [1:0] {
        BNSH_OK = 2'h0,
        BNSH_LOST = 2'h1,
        BNSH_COLL = 2'h2,
        BNSH_WRITE_COLLISION_FLAG = 2'h3
    } bnsh_result_t;
endpackage

// >>> test/bnsh_dev_model.sv
// Behavioural bus node device in SPI mode, master of the serial clock
`timescale 1ns/1ps
`default_nettype none
module bnsh_dev_model #(
    parameter int BC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host-facing pins
    output logic sckPin,
    output logic nodeTxPin,
    input wire logic nodeRxPin,
    input wire logic ctrlIn,
    output logic ctrlLow,
    output logic idleNPin,
    // Traffic from other nodes
    input wire logic inject,
    input wire logic frameErr,
    input wire logic busDrive,
    input wire logic [7:0] busByte,
    output logic [7:0] seen
);
    int ph, bitN, quiet; // Phase, bit index, idle time
    logic act, hold, drv, own; // Frame, fault, bus driven, own request
    // Bit sequencer: data set at phase 0, clock pulse inside the bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            {sckPin, act, hold, ctrlLow, idleNPin} <= 5'h0;
            nodeTxPin <= 1'h1;
            quiet <= 0;
        end
        else if (!act)
        begin
            nodeTxPin <= ~nodeTxPin; // Released line never holds old data
            quiet <= quiet + 1;
            if (quiet == 10 * BC)
                {idleNPin, hold} <= 2'h0;
            if ((!ctrlIn || inject) && !hold)
            begin
                {act, ctrlLow, idleNPin} <= 3'h7;
                ph <= 0;
                bitN <= 0;
                drv <= busDrive | inject;
                own <= !inject;
                hold <= frameErr;
            end
        end
        else
        begin
            ph <= (ph == BC - 1) ? 0 : ph + 1;
            if (ph == 0)
            begin
                nodeTxPin <= (nodeRxPin | !own) & (!drv | busByte[bitN]);
                seen[bitN] <= nodeRxPin;
            end
            if (ph == BC / 4)
                sckPin <= 1'h1;
            if (ph == BC / 2)
            begin
                sckPin <= 1'h0;
                bitN <= bitN + 1;
                // Midpoint of last bit, or a silent stop on a framing fault
                if (bitN == 7 || (hold && bitN == 2))
                begin
                    {act, ctrlLow} <= 2'h0;
                    quiet <= 0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/bnsh_host_properties.sv
// Port checker for the bus node host controller
`timescale 1ns/1ps
`default_nettype none
`include "bnsh_cfg.svh"
module bnsh_host_checker #(
    parameter int CLK_MHZ = 100,
    parameter int BIT_NS = 8000,
    parameter int EOM_BITS = 10,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device pins
    input wire logic sckPin,
    input wire logic nodeRxPin,
    input wire logic ctrlIn,
    input wire logic ctrlOut,
    input wire logic ctrlOe,
    input wire logic modeSel,
    input wire logic chipSelN,
    // Command side
    input wire logic sendStart,
    input wire logic [AW-1:0] sendLen,
    input wire logic sendBusy,
    input wire logic sendDone,
    input wire bnsh_pkg::bnsh_result_t sendResult,
    input wire logic rxValid
);
    import bnsh_pkg::*;
    localparam int BITC = BIT_NS * CLK_MHZ / 1000;
    localparam int REQC = `BNSH_REQ_CYC;
    int oeCnt; // Length of the running request
    int sinceRx; // Quiet time since the last byte
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Run-length counters, cleared by reset so no stale count leaks
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            oeCnt <= 0;
            sinceRx <= 0;
        end
        else
        begin
            oeCnt <= ctrlOe ? oeCnt + 1 : 0;
            sinceRx <= rxValid ? 0 : sinceRx + 1;
        end
    end
    sequence startSeq;
        sendStart && !sendBusy && sendLen != 0;
    endsequence
    sequence reqSeq;
        $rose(ctrlOe) ##1 ctrlOe;
    endsequence
    mode_kept_a: assert property (modeSel && !chipSelN)
        else $error("mode select lost");
    pull_zero_a: assert property (ctrlOe |-> !ctrlOut)
        else $error("handshake not pulled low");
    req_length_a: assert property ($fell(ctrlOe) |-> oeCnt >= REQC)
        else $error("request pulse too short");
    req_start_a: assert property (reqSeq |-> $past(ctrlIn, 3) && sendBusy)
        else $error("request while handshake low");
    busy_start_a: assert property (startSeq |=> sendBusy)
        else $error("send not started");
    done_pulse_a: assert property (sendDone |=> !sendDone)
        else $error("done longer than a cycle");
    eom_gap_a: assert property (sendDone && sendResult == BNSH_OK |-> sinceRx >= EOM_BITS * BITC)
        else $error("end of message too short");
    data_still_a: assert property ($changed(nodeRxPin) |-> !sckPin)
        else $error("host data moved with clock high");
endmodule
bind bnsh_host bnsh_host_checker #(
    .CLK_MHZ(CLK_MHZ), .BIT_NS(BIT_NS), .EOM_BITS(EOM_BITS), .AW(AW)
) bnsh_host_checker_inst (.*);
`default_nettype wire

// >>> test/test_bnsh_host.sv
// Self-checking bench for the bus node host controller
`timescale 1ns/1ps
`default_nettype none
module test_bnsh_host;
    import bnsh_pkg::*;
    logic clk, rst_n, loadEn, sendStart, resync, inject, frameErr, busDrive;
    logic sckPin, nodeTxPin, nodeRxPin, ctrlOut, ctrlOe, ctrlLow, idleNPin, modeSel, chipSelN;
    logic sendBusy, sendDone, rxValid, rxFirst;
    logic [3:0] loadAddr, sendLen;
    logic [7:0] loadData, busByte, seen, rxData;
    bnsh_result_t sendResult;
    logic [7:0] rxq[$]; // Bytes handed up by the host
    int failures = 0;
    int n_checks = 0;
    // Open-drain handshake: either side pulls low, pull-up otherwise
    wire ctrlIn = ctrlOe ? ctrlOut : !ctrlLow;
    bnsh_host #(.BIT_NS(200)) bnsh_host_inst (.*, .ce(1'h1));
    bnsh_dev_model #(.BC(20)) bnsh_dev_model_inst (.*);
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Collect received bytes where they are settled
    always @(negedge clk)
        if (rxValid === 1'h1)
            rxq.push_back(rxData);
    task automatic end_sim();
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bounded wait: for done when nRx is zero, else for nRx bytes
    task automatic wait_for(input int nRx);
        for (int i = 0; i < 20000; i++)
        begin
            @(negedge clk);
            if (nRx == 0 ? sendDone === 1'h1 : rxq.size() >= nRx)
                return;
        end
        failures++;
        end_sim();
    endtask
    // Load two bytes and start a send; entered at a rising edge
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [3:0] n);
        rxq.delete();
        loadEn <= 1'h1;
        loadAddr <= 4'h0;
        loadData <= b0;
        @(posedge clk);
        loadAddr <= 4'h1;
        loadData <= b1;
        @(posedge clk);
        loadEn <= 1'h0;
        sendStart <= 1'h1;
        sendLen <= n;
        @(posedge clk);
        sendStart <= 1'h0;
        wait_for(0);
    endtask
    // Clean two-byte message, echoes match
    task automatic s_send_ok();
        @(posedge clk);
        send(8'ha5, 8'h3c, 4'h2);
        chk("result", 8'(BNSH_OK), 8'(sendResult));
        chk("rxCount", 8'h2, 8'(rxq.size()));
        chk("echo0", 8'ha5, rxq[0]);
        chk("devByte", 8'h3c, seen);
    endtask
    // Another node wins on the first byte; the wired-AND of both bytes comes up
    task automatic s_lost();
        @(posedge clk);
        busDrive <= 1'h1;
        busByte <= 8'h0f;
        send(8'hf0, 8'h00, 4'h1);
        chk("result", 8'(BNSH_LOST), 8'(sendResult));
        chk("ident", 8'h00, rxq[0]);
    endtask
    // Second byte damaged on the bus
    task automatic s_coll();
        @(posedge clk);
        busByte <= 8'hf0;
        send(8'ha0, 8'h5a, 4'h2);
        busDrive <= 1'h0;
        chk("result", 8'(BNSH_COLL), 8'(sendResult));
        chk("echo1", 8'h50, rxq[1]);
    endtask
    // Unsolicited byte from the bus
    task automatic s_recv(input logic [7:0] b);
        @(posedge clk);
        rxq.delete();
        busByte <= b;
        inject <= 1'h1;
        @(posedge clk);
        inject <= 1'h0;
        frameErr <= 1'h0;
        wait_for(1);
        chk("rxByte", b, rxq[0]);
    endtask
    // Framing fault: host resyncs, nothing arrives until end of message
    task automatic s_frame();
        @(posedge clk);
        rxq.delete();
        resync <= 1'h1;
        frameErr <= 1'h1;
        busByte <= 8'h77;
        inject <= 1'h1;
        @(posedge clk);
        inject <= 1'h0;
        frameErr <= 1'h0;
        repeat (300) @(posedge clk);
        chk("rxCount", 8'h0, 8'(rxq.size()));
        chk("firstSet", 8'h1, 8'(rxFirst));
        resync <= 1'h0;
        s_recv(8'h96);
        @(negedge clk);
        chk("firstClr", 8'h0, 8'(rxFirst));
    endtask
    initial
    begin
        {rst_n, loadEn, sendStart, resync, inject, frameErr, busDrive} = 7'h0;
        {loadAddr, sendLen, loadData, busByte} = 24'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        s_send_ok();
        s_lost();
        s_coll();
        s_recv(8'hc3);
        s_frame();
        end_sim();
    end
endmodule
`default_nettype wire
